// ### pkg/lpmc_consts.svh
// Constants of the low power mode controller
`ifndef LPMC_CONSTS_SVH
`define LPMC_CONSTS_SVH
`define LPMC_NPERIPH 8
`define LPMC_NDIV 3
`define LPMC_DIV_W 8
`define LPMC_DIV_ZERO 8'h00
`define LPMC_DIV_ONE 8'h01
`define LPMC_NWAKE 6
`define LPMC_WK_PIN 0
`define LPMC_WK_WDT 1
`define LPMC_WK_TOUCH 2
`define LPMC_WK_USART 3
`define LPMC_WK_SPI 4
`define LPMC_WK_I2C 5
`define LPMC_NSYNC 3
`define LPMC_SY_RST 0
`define LPMC_SY_WAKE 1
`define LPMC_SY_TMR 2
`define LPMC_SYNC_RST 3'h3
`define LPMC_GATE_RST 8'h00
`define LPMC_PERIPH_OFF 8'h00
`define LPMC_TICK_OFF 3'h0
`endif

// ### pkg/lpmc_pkg.sv
// Types of the low power mode controller
package lpmc_pkg;
  typedef enum logic [2:0] {
    lpmc_st_run = 3'b000,
    lpmc_st_sleep = 3'b001,
    lpmc_st_dsleep = 3'b010,
    lpmc_st_pdown = 3'b011,
    lpmc_st_dpd = 3'b100
  } lpmc_state_t;
  typedef enum logic [1:0] {
    lpmc_req_sleep = 2'b00,
    lpmc_req_dsleep = 2'b01,
    lpmc_req_pdown = 2'b10,
    lpmc_req_dpd = 2'b11
  } lpmc_req_t;
  typedef enum logic [1:0] {
    lpmc_fro_18 = 2'b00,
    lpmc_fro_24 = 2'b01,
    lpmc_fro_30 = 2'b10
  } lpmc_fro_t;
  typedef enum logic [1:0] {
    lpmc_div_9 = 2'b00,
    lpmc_div_12 = 2'b01,
    lpmc_div_15 = 2'b10
  } lpmc_frodiv_t;
  typedef enum logic [1:0] {
    lpmc_mux_none = 2'b00,
    lpmc_mux_fro = 2'b01,
    lpmc_mux_ext = 2'b10,
    lpmc_mux_watchdog_osc = 2'b11
  } lpmc_mux_t;
  typedef enum logic {
    lpmc_ext_xtal = 1'b0,
    lpmc_ext_pin = 1'b1
  } lpmc_ext_t;
endpackage

// ### pkg/lpmc_div_if.sv
// Carrier between the controller and a peripheral clock divider
`timescale 1ns/100ps
`include "lpmc_consts.svh"
interface lpmc_div_if;
  logic [`LPMC_DIV_W-1:0] divisor;
  logic run;
  logic tick;
  modport ctl (output divisor, output run, input tick);
  modport div (input divisor, input run, output tick);
endinterface

// ### hdl/lpmc_sync.sv
// Two flop synchroniser for pin level inputs
`timescale 1ns/100ps
`include "lpmc_consts.svh"
module lpmc_sync import lpmc_pkg::*; #(
  parameter int WIDTH = `LPMC_NSYNC,
  parameter logic [WIDTH-1:0] RST = `LPMC_SYNC_RST
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      meta_q <= RST;
      sync_q <= RST;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule

// ### hdl/lpmc_clkdiv.sv
// Programmable peripheral clock divider producing an enable tick
`timescale 1ns/100ps
`include "lpmc_consts.svh"
module lpmc_clkdiv import lpmc_pkg::*; (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // Divider control
  lpmc_div_if.div port
);
  logic [`LPMC_DIV_W-1:0] cnt_q;
  logic tick_q;
  // Divisor zero parks the divider, saving its toggling
  wire stopped = !port.run || (port.divisor == `LPMC_DIV_ZERO);
  wire wrap = (cnt_q >= port.divisor);

  always_ff @(posedge clock_in) begin
    if (!rst_b_in || stopped) begin
      cnt_q <= `LPMC_DIV_ZERO;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= wrap ? `LPMC_DIV_ZERO : cnt_q + `LPMC_DIV_ONE;
      tick_q <= wrap;
    end
  end

  assign port.tick = tick_q;
endmodule

// ### hdl/lpmc_ctrl.sv
// Low power mode controller: mode sequencing, clock and power enables
//
// Behaviour
// RULE1 - Sleep stops core clock, wake reenables it
// RULE2 - Sleep lasts until interrupt or reset
// RULE3 - Peripheral clocks keep running in sleep
// RULE4 - Deep sleep: only FRO, watchdog, low-power oscillators
// RULE5 - Deep sleep: analog off, flash standby
// RULE6 - Deep sleep wake sources listed
// RULE7 - Wake needs system and controller enables
// RULE8 - Power down: all off but selected oscillators
// RULE9 - Power down wakes from deep sleep sources
// RULE10 - Deep power down keeps wake pin, timer
// RULE11 - Lock bit refuses deep power down
// RULE12 - Wake pins held high, no movable function
// RULE13 - Watchdog oscillator, brownout: software, off deep
// RULE14 - Per peripheral clock gate bits
// RULE15 - Own dividers for selected peripherals
// RULE16 - Clock muxes offer tied off none input
// RULE17 - Watchdog clock only when run bit set
// RULE18 - Divided FRO runs 15, 12 or 9
// RULE19 - External clock from crystal or pin
`timescale 1ns/100ps
`include "lpmc_consts.svh"
module lpmc_ctrl import lpmc_pkg::*; (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // Core request
  input wire logic sleep_req_in,
  input wire lpmc_req_t mode_req_in,
  input wire logic irq_pending_in,
  // Wake sources and enables
  input wire logic [`LPMC_NWAKE-1:0] wake_src_in,
  input wire logic [`LPMC_NWAKE-1:0] start_en_in,
  input wire logic [`LPMC_NWAKE-1:0] nic_en_in,
  input wire logic usart_sync_slave_in,
  input wire logic spi_slave_in,
  input wire logic i2c_slave_in,
  // Pins and timer
  input wire logic reset_pin_b_in,
  input wire logic wake_pin_b_in,
  input wire logic wake_timeout_in,
  // Power management configuration
  input wire logic dpd_lock_in,
  input wire logic wake_pin_en_in,
  input wire logic reset_wake_en_in,
  input wire logic lposc_en_in,
  input wire logic lposc_dpd_en_in,
  input wire logic pdrun_watchdog_osc_in,
  input wire logic bod_en_in,
  input wire logic pll_en_in,
  input wire logic xtal_en_in,
  // Clock configuration
  input wire logic [`LPMC_NPERIPH-1:0] periph_gate_in,
  input wire logic [`LPMC_NDIV-1:0][`LPMC_DIV_W-1:0] div_value_in,
  input wire lpmc_fro_t fro_sel_in,
  input wire lpmc_ext_t ext_sel_in,
  input wire lpmc_mux_t clk_mux_sel_in,
  // Mode status
  output lpmc_state_t mode_out,
  output logic wake_out,
  output logic dpd_refused_out,
  // Clock enables
  output logic core_clk_en_out,
  output logic [`LPMC_NPERIPH-1:0] periph_clk_en_out,
  output logic [`LPMC_NDIV-1:0] periph_tick_out,
  output lpmc_frodiv_t fro_div_rate_out,
  output logic ext_from_xtal_out,
  output logic ext_from_pin_out,
  output lpmc_mux_t clk_mux_src_out,
  output logic watchdog_osc_clk_avail_out,
  // Power enables
  output logic fro_on_out,
  output logic fro_out_en_out,
  output logic flash_on_out,
  output logic flash_standby_out,
  output logic analog_on_out,
  output logic pll_on_out,
  output logic crystal_osc_on_out,
  output logic watchdog_osc_on_out,
  output logic lposc_on_out,
  output logic bod_on_out,
  output logic core_power_on_out
);
  lpmc_state_t state_q, state_d;
  logic [`LPMC_NSYNC-1:0] pins_s;
  logic wake_q, refused_q;
  logic core_clk_q, fro_q, fro_out_q, flash_q, standby_q, analog_q;
  logic pll_q, xtal_q, watchdog_osc_q, lposc_q, bod_q, power_q;
  logic [`LPMC_NPERIPH-1:0] periph_q;
  lpmc_frodiv_t frodiv_q;
  lpmc_mux_t mux_q;
  logic ext_xtal_q, ext_pin_q, wdclk_q;

  // Pin levels cross in before any decode
  lpmc_sync #(.WIDTH(`LPMC_NSYNC), .RST(`LPMC_SYNC_RST)) u_sync (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .async_in({wake_timeout_in, wake_pin_b_in, reset_pin_b_in}),
    .sync_out(pins_s)
  );

  // Pins idle high, so a low level is the wake request
  wire rst_pin_hit = !pins_s[`LPMC_SY_RST]; // RULE12
  wire wake_pin_hit = !pins_s[`LPMC_SY_WAKE]; // RULE12
  wire timer_hit = pins_s[`LPMC_SY_TMR];

  // Serial wake sources count only in their slave modes
  wire [`LPMC_NWAKE-1:0] slave_ok = {i2c_slave_in, spi_slave_in, usart_sync_slave_in, 3'h7}; // RULE6
  wire [`LPMC_NWAKE-1:0] wake_qual = wake_src_in & slave_ok & start_en_in & nic_en_in; // RULE7
  wire deep_wake = (|wake_qual) || rst_pin_hit; // RULE6 RULE9
  wire sleep_wake = irq_pending_in || rst_pin_hit; // RULE2
  wire lposc_dpd_run = lposc_en_in && lposc_dpd_en_in; // RULE10
  wire dpd_wake = (wake_pin_hit && wake_pin_en_in) || (rst_pin_hit && reset_wake_en_in) ||
                  (timer_hit && lposc_dpd_run); // RULE10
  wire want_dpd = sleep_req_in && (mode_req_in == lpmc_req_dpd);
  wire dpd_refuse = (state_q == lpmc_st_run) && want_dpd && dpd_lock_in; // RULE11

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      lpmc_st_run: begin
        if (sleep_req_in) begin
          unique case (mode_req_in)
            lpmc_req_sleep: state_d = lpmc_st_sleep; // RULE1
            lpmc_req_dsleep: state_d = lpmc_st_dsleep;
            lpmc_req_pdown: state_d = lpmc_st_pdown;
            lpmc_req_dpd: state_d = dpd_lock_in ? lpmc_st_run : lpmc_st_dpd; // RULE11
          endcase
        end
      end
      lpmc_st_sleep: begin
        if (sleep_wake) begin
          state_d = lpmc_st_run; // RULE1 RULE2
        end
      end
      lpmc_st_dsleep: begin
        if (deep_wake) begin
          state_d = lpmc_st_run; // RULE6
        end
      end
      lpmc_st_pdown: begin
        if (deep_wake) begin
          state_d = lpmc_st_run; // RULE9
        end
      end
      lpmc_st_dpd: begin
        if (dpd_wake) begin
          state_d = lpmc_st_run; // RULE10
        end
      end
      default: state_d = lpmc_st_run;
    endcase
  end

  // Enables are decoded from the next state so they line up with mode_out
  wire n_run = (state_d == lpmc_st_run);
  wire n_awake = n_run || (state_d == lpmc_st_sleep);
  wire n_dsleep = (state_d == lpmc_st_dsleep);
  wire n_dpd = (state_d == lpmc_st_dpd);
  wire core_clk_d = n_run; // RULE1
  wire [`LPMC_NPERIPH-1:0] periph_d = n_awake ? ~periph_gate_in : `LPMC_PERIPH_OFF; // RULE3 RULE4 RULE8 RULE14
  wire fro_d = n_awake || n_dsleep; // RULE4 RULE8
  wire fro_out_d = n_awake; // RULE4
  wire flash_d = n_awake || n_dsleep; // RULE5 RULE8
  wire standby_d = n_dsleep; // RULE5
  wire analog_d = n_awake; // RULE5 RULE8
  wire pll_d = n_awake && pll_en_in; // RULE4 RULE8
  wire xtal_need = xtal_en_in || (ext_sel_in == lpmc_ext_xtal && clk_mux_sel_in == lpmc_mux_ext);
  wire xtal_d = n_awake && xtal_need; // RULE4 RULE8
  wire watchdog_osc_d = !n_dpd && pdrun_watchdog_osc_in; // RULE13
  wire bod_d = !n_dpd && bod_en_in; // RULE13
  wire lposc_d = n_dpd ? lposc_dpd_run : lposc_en_in; // RULE10
  wire power_d = !n_dpd; // RULE10

  // Unpowered watchdog oscillator falls back to the tied off input
  wire wdclk_d = watchdog_osc_d; // RULE17
  wire mux_dead = (clk_mux_sel_in == lpmc_mux_watchdog_osc) && !wdclk_d;
  wire lpmc_mux_t mux_d = mux_dead ? lpmc_mux_none : clk_mux_sel_in; // RULE16 RULE17
  wire ext_xtal_d = (ext_sel_in == lpmc_ext_xtal); // RULE19
  wire ext_pin_d = (ext_sel_in == lpmc_ext_pin); // RULE19

  // Divided FRO is half the selected oscillator rate
  lpmc_frodiv_t frodiv_d;
  always_comb begin
    unique case (fro_sel_in)
      lpmc_fro_18: frodiv_d = lpmc_div_9; // RULE18
      lpmc_fro_24: frodiv_d = lpmc_div_12; // RULE18
      lpmc_fro_30: frodiv_d = lpmc_div_15; // RULE18
      default: frodiv_d = lpmc_div_12;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      state_q <= lpmc_st_run;
      wake_q <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      state_q <= state_d;
      wake_q <= (state_q != lpmc_st_run) && n_run;
      refused_q <= dpd_refuse;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      core_clk_q <= 1'b1;
      periph_q <= ~`LPMC_GATE_RST;
      fro_q <= 1'b1;
      fro_out_q <= 1'b1;
      flash_q <= 1'b1;
      standby_q <= 1'b0;
      analog_q <= 1'b1;
      power_q <= 1'b1;
    end else begin
      core_clk_q <= core_clk_d;
      periph_q <= periph_d;
      fro_q <= fro_d;
      fro_out_q <= fro_out_d;
      flash_q <= flash_d;
      standby_q <= standby_d;
      analog_q <= analog_d;
      power_q <= power_d;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      pll_q <= 1'b0;
      xtal_q <= 1'b0;
      watchdog_osc_q <= 1'b0;
      lposc_q <= 1'b0;
      bod_q <= 1'b0;
      wdclk_q <= 1'b0;
      mux_q <= lpmc_mux_none;
      frodiv_q <= lpmc_div_12;
      ext_xtal_q <= 1'b1;
      ext_pin_q <= 1'b0;
    end else begin
      pll_q <= pll_d;
      xtal_q <= xtal_d;
      watchdog_osc_q <= watchdog_osc_d;
      lposc_q <= lposc_d;
      bod_q <= bod_d;
      wdclk_q <= wdclk_d;
      mux_q <= mux_d;
      frodiv_q <= frodiv_d;
      ext_xtal_q <= ext_xtal_d;
      ext_pin_q <= ext_pin_d;
    end
  end

  // Dividers only count while their peripheral clock is enabled
  lpmc_div_if div_if [`LPMC_NDIV] ();
  for (genvar g = 0; g < `LPMC_NDIV; g++) begin : g_div
    assign div_if[g].divisor = div_value_in[g];
    assign div_if[g].run = periph_q[g]; // RULE15
    assign periph_tick_out[g] = div_if[g].tick;
    lpmc_clkdiv u_div (
      .clock_in(clock_in),
      .rst_b_in(rst_b_in),
      .port(div_if[g])
    );
  end

  assign mode_out = state_q;
  assign wake_out = wake_q;
  assign dpd_refused_out = refused_q;
  assign core_clk_en_out = core_clk_q;
  assign periph_clk_en_out = periph_q;
  assign fro_div_rate_out = frodiv_q;
  assign ext_from_xtal_out = ext_xtal_q;
  assign ext_from_pin_out = ext_pin_q;
  assign clk_mux_src_out = mux_q;
  assign watchdog_osc_clk_avail_out = wdclk_q;
  assign fro_on_out = fro_q;
  assign fro_out_en_out = fro_out_q;
  assign flash_on_out = flash_q;
  assign flash_standby_out = standby_q;
  assign analog_on_out = analog_q;
  assign pll_on_out = pll_q;
  assign crystal_osc_on_out = xtal_q;
  assign watchdog_osc_on_out = watchdog_osc_q;
  assign lposc_on_out = lposc_q;
  assign bod_on_out = bod_q;
  assign core_power_on_out = power_q;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);

  sequence s_run_sleep_req;
    (state_q == lpmc_st_run) && sleep_req_in && (mode_req_in == lpmc_req_sleep);
  endsequence
  sequence s_in_sleep;
    (state_q == lpmc_st_sleep) && !core_clk_en_out;
  endsequence

  property p_sleep_stop;
    s_run_sleep_req |=> s_in_sleep;
  endproperty
  a_sleep_stop: assert property (p_sleep_stop) else $error("core clock not stopped in sleep"); // RULE1

  property p_sleep_hold;
    (state_q == lpmc_st_sleep) && !irq_pending_in && !rst_pin_hit |=> (state_q == lpmc_st_sleep);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("sleep left without cause"); // RULE2

  property p_sleep_wake;
    (state_q == lpmc_st_sleep) && irq_pending_in |=> core_clk_en_out && wake_out;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("interrupt did not end sleep"); // RULE2

  property p_sleep_periph;
    (state_q == lpmc_st_sleep) |-> (periph_clk_en_out == ~$past(periph_gate_in));
  endproperty
  a_sleep_periph: assert property (p_sleep_periph) else $error("peripheral clocks wrong in sleep"); // RULE3

  property p_dsleep_pwr;
    (state_q == lpmc_st_dsleep) |-> fro_on_out && !fro_out_en_out && !analog_on_out &&
      flash_on_out && flash_standby_out && !pll_on_out && (periph_clk_en_out == `LPMC_PERIPH_OFF);
  endproperty
  a_dsleep_pwr: assert property (p_dsleep_pwr) else $error("deep sleep enables wrong"); // RULE4

  property p_pdown_pwr;
    (state_q == lpmc_st_pdown) |-> !fro_on_out && !flash_on_out && !analog_on_out && !crystal_osc_on_out;
  endproperty
  a_pdown_pwr: assert property (p_pdown_pwr) else $error("power down enables wrong"); // RULE8

  property p_deep_gate;
    (state_q == lpmc_st_dsleep || state_q == lpmc_st_pdown) && !rst_pin_hit &&
      ((wake_src_in & start_en_in & nic_en_in) == '0) |=> (state_q == $past(state_q));
  endproperty
  a_deep_gate: assert property (p_deep_gate) else $error("deep wake without both enables"); // RULE7

  property p_deep_wake;
    (state_q == lpmc_st_pdown) && wake_src_in[`LPMC_WK_WDT] && start_en_in[`LPMC_WK_WDT] &&
      nic_en_in[`LPMC_WK_WDT] |=> (state_q == lpmc_st_run) && wake_out;
  endproperty
  a_deep_wake: assert property (p_deep_wake) else $error("watchdog did not wake power down"); // RULE9

  property p_dpd_off;
    (state_q == lpmc_st_dpd) |-> !core_power_on_out && !bod_on_out && !watchdog_osc_on_out &&
      (lposc_on_out == $past(lposc_dpd_run));
  endproperty
  a_dpd_off: assert property (p_dpd_off) else $error("deep power down enables wrong"); // RULE10 RULE13

  property p_dpd_lock;
    (state_q == lpmc_st_run) && want_dpd && dpd_lock_in |=> (state_q == lpmc_st_run) && dpd_refused_out;
  endproperty
  a_dpd_lock: assert property (p_dpd_lock) else $error("locked deep power down entered"); // RULE11

  property p_wdclk;
    (clk_mux_src_out == lpmc_mux_watchdog_osc) |-> watchdog_osc_clk_avail_out && watchdog_osc_on_out;
  endproperty
  a_wdclk: assert property (p_wdclk) else $error("watchdog clock selected while off"); // RULE17 RULE16

  property p_frodiv;
    (fro_sel_in == lpmc_fro_30) |=> (fro_div_rate_out == lpmc_div_15);
  endproperty
  a_frodiv: assert property (p_frodiv) else $error("divided FRO rate wrong"); // RULE18
endmodule

// ### tb/lpmc_core_model.sv
// Core and wake source model facing the controller
`timescale 1ns/100ps
`include "lpmc_consts.svh"
module lpmc_core_model import lpmc_pkg::*; (
  // Bench control
  input wire logic go_in,
  input wire lpmc_req_t mode_sel_in,
  input wire logic [`LPMC_NWAKE-1:0] start_arm_in,
  input wire logic [`LPMC_NWAKE-1:0] nic_arm_in,
  input wire logic pin_wake_in,
  // Controller side
  input wire lpmc_state_t mode_in,
  output logic sleep_req_out,
  output lpmc_req_t mode_req_out,
  output logic [`LPMC_NWAKE-1:0] start_en_out,
  output logic [`LPMC_NWAKE-1:0] nic_en_out,
  output logic wake_pin_b_out
);
  // Core can only ask while it still runs
  assign sleep_req_out = go_in && (mode_in == lpmc_st_run);
  assign mode_req_out = mode_sel_in;
  // Arms kept apart so a bench can leave one enable out
  assign start_en_out = start_arm_in;
  assign nic_en_out = nic_arm_in;
  // Pin stays high until the deep power-down wake is wanted
  assign wake_pin_b_out = !(pin_wake_in && mode_in == lpmc_st_dpd);
endmodule

// ### tb/low_power_mode_controller_tb.sv
// Self-checking bench of the low power mode controller
`timescale 1ns/100ps
`include "lpmc_consts.svh"
module low_power_mode_controller_tb import lpmc_pkg::*; ;
  logic clock_in, rst_b_in, go, irq, us_s, spi_s, i2c_s, rpin_b, tmo, lock, pdrun, pinwk, brownout_detector, lpd;
  lpmc_req_t msel, mreq;
  logic [5:0] wsrc, sarm, narm, sen, nen;
  logic [7:0] gate, pen;
  logic [2:0][7:0] divv;
  lpmc_fro_t frosel;
  lpmc_ext_t extsel;
  lpmc_mux_t muxsel, msrc;
  lpmc_state_t mode;
  lpmc_frodiv_t rate;
  logic [2:0] tck;
  logic sreq, wpin_b, wake, refused, coreen, ext_x, ext_p, wdav, froon, froen, flon, stby, anon;
  logic pllon, xton, wdon, lpon, bodon, pwon;
  int err_total, n_tests, i, k, b;
  logic [23:0] rows [4];

  lpmc_core_model core (.go_in(go), .mode_sel_in(msel), .start_arm_in(sarm), .nic_arm_in(narm),
    .pin_wake_in(pinwk), .mode_in(mode), .sleep_req_out(sreq), .mode_req_out(mreq),
    .start_en_out(sen), .nic_en_out(nen), .wake_pin_b_out(wpin_b));

  lpmc_ctrl dut (.clock_in(clock_in), .rst_b_in(rst_b_in), .sleep_req_in(sreq), .mode_req_in(mreq),
    .irq_pending_in(irq), .wake_src_in(wsrc), .start_en_in(sen), .nic_en_in(nen),
    .usart_sync_slave_in(us_s), .spi_slave_in(spi_s), .i2c_slave_in(i2c_s),
    .reset_pin_b_in(rpin_b), .wake_pin_b_in(wpin_b), .wake_timeout_in(tmo), .dpd_lock_in(lock),
    .wake_pin_en_in(1'b1), .reset_wake_en_in(1'b1), .lposc_en_in(1'b1), .lposc_dpd_en_in(lpd),
    .pdrun_watchdog_osc_in(pdrun), .bod_en_in(brownout_detector), .pll_en_in(1'b0), .xtal_en_in(1'b0),
    .periph_gate_in(gate), .div_value_in(divv), .fro_sel_in(frosel), .ext_sel_in(extsel),
    .clk_mux_sel_in(muxsel), .mode_out(mode), .wake_out(wake), .dpd_refused_out(refused),
    .core_clk_en_out(coreen), .periph_clk_en_out(pen), .periph_tick_out(tck),
    .fro_div_rate_out(rate), .ext_from_xtal_out(ext_x), .ext_from_pin_out(ext_p),
    .clk_mux_src_out(msrc), .watchdog_osc_clk_avail_out(wdav), .fro_on_out(froon),
    .fro_out_en_out(froen), .flash_on_out(flon), .flash_standby_out(stby),
    .analog_on_out(anon), .pll_on_out(pllon), .crystal_osc_on_out(xton),
    .watchdog_osc_on_out(wdon), .lposc_on_out(lpon), .bod_on_out(bodon), .core_power_on_out(pwon));

  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end

  task automatic tick(input int n = 1);
    repeat (n) @(posedge clock_in);
    #10;
  endtask

  task automatic chk(input logic [23:0] seen, input logic [23:0] want);
    n_tests++;
    if (seen !== want) begin
      err_total++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, want);
    end
  endtask

  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // One request pulse while running
  task automatic enter(input lpmc_req_t m);
    go = 1'b1;
    msel = m;
    tick();
    go = 1'b0;
  endtask

  // Bounded wait for the return to run
  task automatic wait_run;
    for (k = 0; k < 8 && mode !== lpmc_st_run; k++) tick();
  endtask

  function automatic logic [23:0] snap();
    return {5'h00, mode, coreen, froon, froen, stby, anon, pwon, bodon, wdon, pen};
  endfunction

  initial begin
    // Watchdog on the whole run, far above the expected length
    #400000;
    err_total++;
    stop_test();
  end

  initial begin
    rows[0] = 24'h016FFF;
    rows[1] = 24'h025700;
    rows[2] = 24'h030700;
    rows[3] = 24'h040000;
    err_total = 0;
    n_tests = 0;
    {rst_b_in, go, irq, tmo, lock, pinwk} = 6'h00;
    {us_s, spi_s, i2c_s, rpin_b, pdrun, brownout_detector, lpd} = 7'h7F;
    msel = lpmc_req_sleep;
    {wsrc, gate, divv} = 38'h0;
    sarm = 6'h3F;
    narm = 6'h3F;
    frosel = lpmc_fro_24;
    extsel = lpmc_ext_xtal;
    muxsel = lpmc_mux_none;
    tick(3);
    chk(snap(), 24'h00ECFF);
    chk({14'h0, msrc, rate, ext_x, tck, wake, refused}, {14'h0, lpmc_mux_none, lpmc_div_12, 4'h8, 2'h0});
    chk({21'h0, pllon, xton, lpon}, 24'h0);
    tick();
    rst_b_in = 1'b1;
    tick(2);
    $display("Reset test done");
    for (i = 0; i < 4; i++) begin
      enter(lpmc_req_t'(i));
      chk(snap(), rows[i]);
      if (i == 0) irq = 1'b1;
      else if (i == 3) pinwk = 1'b1;
      else wsrc = 6'h02;
      wait_run();
      chk({22'h0, wake, coreen}, 24'h3);
      {irq, pinwk, wsrc} = 8'h00;
      tick(3);
      chk({22'h0, wake, coreen}, 24'h1);
      $display("Mode row %0d done", i);
    end
    lock = 1'b1;
    enter(lpmc_req_dpd);
    chk({20'h0, mode, refused}, {20'h0, lpmc_st_run, 1'b1});
    tick();
    chk({23'h0, refused}, 24'h0);
    lock = 1'b0;
    $display("Lock test done");
    // Wake bits tried with a missing enable or slave mode first
    for (b = 0; b < 6; b++) begin
      enter(b[0] ? lpmc_req_pdown : lpmc_req_dsleep);
      {us_s, spi_s, i2c_s} = 3'h0;
      narm = 6'h00;
      wsrc = 6'h01 << b;
      tick(4);
      chk({21'h0, mode}, {21'h0, b[0] ? lpmc_st_pdown : lpmc_st_dsleep});
      narm = 6'h3F;
      if (b >= 3) begin
        tick(4);
        chk({21'h0, mode}, {21'h0, b[0] ? lpmc_st_pdown : lpmc_st_dsleep});
        {us_s, spi_s, i2c_s} = 3'h7;
      end
      wait_run();
      chk({21'h0, mode}, {21'h0, lpmc_st_run});
      wsrc = 6'h00;
      tick();
    end
    $display("Wake source test done");
    for (b = 0; b < 2; b++) begin
      enter(lpmc_req_dpd);
      if (b == 0) tmo = 1'b1;
      else rpin_b = 1'b0;
      wait_run();
      chk({21'h0, mode}, {21'h0, lpmc_st_run});
      tmo = 1'b0;
      rpin_b = 1'b1;
      tick(3);
    end
    $display("Deep wake test done");
    // Timer wake must fail once the low-power oscillator is not kept in DPD
    lpd = 1'b0;
    brownout_detector = 1'b0;
    enter(lpmc_req_dpd);
    tmo = 1'b1;
    tick(4);
    chk({21'h0, mode}, {21'h0, lpmc_st_dpd});
    chk({23'h0, lpon}, 24'h0);
    rpin_b = 1'b0;
    wait_run();
    chk({21'h0, mode}, {21'h0, lpmc_st_run});
    chk({23'h0, bodon}, 24'h0);
    {tmo, rpin_b, lpd, brownout_detector} = 4'h7;
    tick(3);
    $display("Timer lock out test done");
    // Reset taken while in deep sleep
    enter(lpmc_req_dsleep);
    rst_b_in = 1'b0;
    tick();
    chk(snap(), 24'h00ECFF);
    rst_b_in = 1'b1;
    tick();
    chk(snap(), 24'h00EFFF);
    chk({23'h0, wake}, 24'h0);
    tick(2);
    $display("Mid-run reset test done");
    gate = 8'hA5;
    tick();
    chk({16'h0, pen}, 24'h00005A);
    gate = 8'h00;
    for (i = 0; i < 3; i++) begin
      frosel = lpmc_fro_t'(i);
      tick();
      chk({22'h0, rate}, {22'h0, lpmc_frodiv_t'(i)});
    end
    extsel = lpmc_ext_pin;
    tick();
    chk({22'h0, ext_x, ext_p}, 24'h1);
    for (i = 0; i < 4; i++) begin
      muxsel = lpmc_mux_t'(i);
      tick();
      chk({21'h0, msrc, wdav}, {21'h0, lpmc_mux_t'(i), 1'b1});
    end
    pdrun = 1'b0;
    tick();
    chk({21'h0, msrc, wdav}, {21'h0, lpmc_mux_none, 1'b0});
    extsel = lpmc_ext_xtal;
    muxsel = lpmc_mux_ext;
    tick();
    chk({21'h0, pllon, xton, lpon}, 24'h3);
    $display("Clock select test done");
    divv[0] = 8'h02;
    for (k = 0; k < 10 && tck[0] !== 1'b1; k++) tick();
    tick();
    chk({21'h0, tck}, 24'h0);
    tick();
    chk({21'h0, tck}, 24'h0);
    tick();
    chk({21'h0, tck}, 24'h1);
    $display("Divider test done");
    stop_test();
  end
endmodule
